// file: logic/msio_ctl_regs.sv
// Device control, GPIO data and shared DAC preset registers.
// Assumes the serial front end on clk_sys_i opens a burst with
// acc_start_i and then gives one acc_valid_i pulse per word.
`timescale 1ns/1ps
module msio_ctl_regs (
   // Clock and reset.
   input  wire logic        clk_sys_i,
   input  wire logic        resetn_i,
   // Register access from the serial front end.
   input  wire logic        acc_start_i,
   input  wire logic [6:0]  acc_addr_i,
   input  wire logic        acc_write_i,
   input  wire logic        acc_valid_i,
   input  wire logic [15:0] acc_wdata_i,
   output logic      [15:0] acc_rdata_o,
   output logic             acc_rvalid_o,
   output logic      [6:0]  acc_addr_o,
   // Port configuration from the port setup logic.
   input  wire logic [19:0] port_is_adc_i,
   input  wire logic [19:0] port_is_dac_i,
   input  wire logic [19:0] port_is_gpi_i,
   input  wire logic [19:0] port_is_gpo_i,
   // Digital port pins.
   input  wire logic [19:0] gpi_pin_i,
   output logic      [19:0] gpo_level_o,
   output logic      [19:0] gpo_oe_o,
   // Internal temperature result.
   input  wire logic [11:0] int_temp_i,
   input  wire logic        int_temp_valid_i,
   // Control outputs to the analog sections.
   output logic      [2:0]  temp_monitor_enables_o,
   output logic             temp_conv_time_sel_o,
   output logic             dac_reference_sel_o,
   output logic             series_resistance_comp_o,
   output logic      [1:0]  dac_update_mode_o,
   output logic             low_power_sel_o,
   output logic             ports_hiz_o,
   output logic             device_reset_o,
   output logic             power_on_seq_o,
   output logic             dac_preset_active_o,
   output logic      [11:0] dac_preset_value_o
);

   // ****************************************************************
   // State of the bank.
   // ****************************************************************
   typedef struct packed {
      logic [15:0] ctl;     // Device control, reset bit never stored.
      logic [19:0] gpo;     // Output port levels.
      logic [11:0] pre1;    // First shared DAC value.
      logic [11:0] pre2;    // Second shared DAC value.
      logic [6:0]  addr;    // Current burst address.
      logic [15:0] rdata;   // Read data for the front end.
      logic        rvalid;  // Read data strobe.
      logic        rst_req; // Device reset pulse.
      logic        lp_exit; // Power-on sequence request pulse.
   } regs_t;

   regs_t r_q; // Registered state.
   regs_t r_d; // Next state.

   logic [19:0] gpi_level;  // Synchronised pin levels.
   logic [19:0] gpi_seen;   // Levels of GPI-configured ports only.
   logic        is_write;   // Current word is a write.
   logic        is_read;    // Current word is a read.
   logic        in_adc;     // Address lies in the ADC data range.
   logic        in_dac;     // Address lies in the DAC data range.
   logic        ctx_step;   // Contextual stepping applies.
   logic [6:0]  seek_base;  // Base of the range being searched.
   logic [4:0]  seek_idx;   // Port index of the current address.
   logic [4:0]  seek_next;  // Next configured port index.
   logic        seek_found; // A configured port exists.
   logic [6:0]  step_addr;  // Address after the current word.
   logic        overtemp;   // Overtemperature trip condition.

   // ****************************************************************
   // Helpers.
   // ****************************************************************

   // True when an address falls inside a 20-register port range.
   function automatic logic in_range(input logic [6:0] a,
                                     input logic [6:0] base);
      logic [6:0] off;
      off      = a - base;
      in_range = (a >= base) && (off < 7'(msio_ctl_pkg::NUM_PORTS));
   endfunction : in_range

   // Pin synchroniser.
   msio_level_sync u_sync (
      .clk_sys_i (clk_sys_i),
      .resetn_i  (resetn_i),
      .pin_i     (gpi_pin_i),
      .level_o   (gpi_level)
   );

   assign gpi_seen = gpi_level & port_is_gpi_i;

   // ****************************************************************
   // Burst address stepping.
   // ****************************************************************
   assign is_write  = acc_valid_i && acc_write_i;
   assign is_read   = acc_valid_i && !acc_write_i;
   assign in_adc    = in_range(r_q.addr, msio_ctl_pkg::ADC_DATA_BASE_OFS);
   assign in_dac    = in_range(r_q.addr, msio_ctl_pkg::DAC_DATA_BASE_OFS);
   assign seek_base = acc_write_i ? msio_ctl_pkg::DAC_DATA_BASE_OFS
                                  : msio_ctl_pkg::ADC_DATA_BASE_OFS;
   assign seek_idx  = 5'(r_q.addr - seek_base);

   // Only ADC reads and DAC writes step contextually; DAC reads do not.
   assign ctx_step = r_q.ctl[msio_ctl_pkg::BURST_POLICY_BIT] &&
                     ((is_read && in_adc) || (is_write && in_dac));

   // Search the ADC mask for reads and the DAC mask for writes.
   msio_port_seek u_seek (
      .cur_idx_i  (seek_idx),
      .mask_i     (acc_write_i ? port_is_dac_i : port_is_adc_i),
      .next_idx_o (seek_next),
      .found_o    (seek_found)
   );

   // Contextual step lands on the next configured port; else plus one.
   always_comb begin
      if (ctx_step && seek_found) begin
         step_addr = seek_base + 7'(seek_next);
      end else begin
         step_addr = r_q.addr + 7'h01;
      end
   end

   // ****************************************************************
   // Thermal trip.
   // ****************************************************************
   // Trips only with the shutdown enable and internal monitor both on.
   assign overtemp = r_q.ctl[msio_ctl_pkg::OVERTEMP_BIT] &&
                     r_q.ctl[msio_ctl_pkg::TEMP_MON_LSB] &&
                     int_temp_valid_i &&
                     ($signed(int_temp_i) >
                      $signed(msio_ctl_pkg::TRIP_TEMP_CODE));

   // ****************************************************************
   // Next-state logic.
   // ****************************************************************
   // Handles address, reads and writes, then reset requests.
   always_comb begin
      r_d         = r_q;
      r_d.rvalid  = 1'b0;
      r_d.rst_req = 1'b0;
      r_d.lp_exit = 1'b0;
      // A new burst loads its start address.
      if (acc_start_i) begin
         r_d.addr = acc_addr_i;
      end else if (acc_valid_i) begin
         r_d.addr = step_addr;
      end
      // Register writes.
      if (is_write && !acc_start_i) begin
         case (r_q.addr)
            msio_ctl_pkg::DEVICE_CONTROL_OFS: begin
               if (acc_wdata_i[msio_ctl_pkg::SOFT_RESET_BIT]) begin
                  r_d.rst_req = 1'b1;
               end else begin
                  r_d.ctl = acc_wdata_i;
                  // Falling low power bit asks for power-on sequence.
                  r_d.lp_exit =
                     r_q.ctl[msio_ctl_pkg::LOW_POWER_BIT] &&
                     !acc_wdata_i[msio_ctl_pkg::LOW_POWER_BIT];
               end
            end
            msio_ctl_pkg::OUTPUT_LEVEL_LOW_OFS: begin
               r_d.gpo[15:0] = acc_wdata_i;
            end
            msio_ctl_pkg::OUTPUT_LEVEL_HIGH_OFS: begin
               r_d.gpo[19:16] = acc_wdata_i[3:0];
            end
            // Preset writes touch only the preset itself.
            msio_ctl_pkg::SHARED_DAC_ONE_OFS: begin
               r_d.pre1 = acc_wdata_i[11:0];
            end
            msio_ctl_pkg::SHARED_DAC_TWO_OFS: begin
               r_d.pre2 = acc_wdata_i[11:0];
            end
            // Input level registers and unmapped words ignore writes.
            default: begin
               r_d.ctl = r_q.ctl;
            end
         endcase
      end
      // Register reads; unmapped and port data words return zero.
      if (is_read && !acc_start_i) begin
         r_d.rvalid = 1'b1;
         case (r_q.addr)
            msio_ctl_pkg::DEVICE_CONTROL_OFS: begin
               r_d.rdata = r_q.ctl;
            end
            msio_ctl_pkg::INPUT_LEVEL_LOW_OFS: begin
               r_d.rdata = gpi_seen[15:0];
            end
            msio_ctl_pkg::INPUT_LEVEL_HIGH_OFS: begin
               r_d.rdata = {12'h000, gpi_seen[19:16]};
            end
            msio_ctl_pkg::OUTPUT_LEVEL_LOW_OFS: begin
               r_d.rdata = r_q.gpo[15:0];
            end
            msio_ctl_pkg::OUTPUT_LEVEL_HIGH_OFS: begin
               r_d.rdata = {12'h000, r_q.gpo[19:16]};
            end
            msio_ctl_pkg::SHARED_DAC_ONE_OFS: begin
               r_d.rdata = {4'h0, r_q.pre1};
            end
            msio_ctl_pkg::SHARED_DAC_TWO_OFS: begin
               r_d.rdata = {4'h0, r_q.pre2};
            end
            default: begin
               r_d.rdata = 16'h0000;
            end
         endcase
      end
      // Overtemperature trip also raises a device reset.
      if (overtemp) begin
         r_d.rst_req = 1'b1;
      end
      // A pending reset pulse returns every register to default.
      if (r_q.rst_req) begin
         r_d      = '0;
         r_d.ctl  = msio_ctl_pkg::DEVICE_CONTROL_RST;
         r_d.gpo  = msio_ctl_pkg::OUTPUT_LEVEL_RST;
         r_d.pre1 = msio_ctl_pkg::SHARED_DAC_RST;
         r_d.pre2 = msio_ctl_pkg::SHARED_DAC_RST;
      end
   end

   // Registers the state; the power-on reset clears it all.
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   // ****************************************************************
   // Outputs.
   // ****************************************************************
   assign acc_rdata_o  = r_q.rdata;
   assign acc_rvalid_o = r_q.rvalid;
   assign acc_addr_o   = r_q.addr;

   assign temp_monitor_enables_o =
      r_q.ctl[msio_ctl_pkg::TEMP_MON_LSB +: 3];
   assign temp_conv_time_sel_o =
      r_q.ctl[msio_ctl_pkg::TEMP_CONV_BIT];
   assign dac_reference_sel_o      = r_q.ctl[msio_ctl_pkg::DAC_REF_BIT];
   assign series_resistance_comp_o = r_q.ctl[msio_ctl_pkg::SERIES_COMP_BIT];
   assign dac_update_mode_o = r_q.ctl[msio_ctl_pkg::DAC_MODE_LSB +: 2];
   assign low_power_sel_o   = r_q.ctl[msio_ctl_pkg::LOW_POWER_BIT];

   // Ports float in low power and while the device resets.
   assign ports_hiz_o    = low_power_sel_o || r_q.rst_req;
   assign device_reset_o = r_q.rst_req;
   assign power_on_seq_o = r_q.lp_exit;

   // GPO ports drive their stored level unless floated.
   assign gpo_level_o = r_q.gpo & port_is_gpo_i;
   assign gpo_oe_o    = ports_hiz_o ? 20'h00000 : port_is_gpo_i;

   // Preset modes send one shared value to every DAC port.
   assign dac_preset_active_o =
      (dac_update_mode_o == msio_ctl_pkg::DAC_MODE_PRESET1) ||
      (dac_update_mode_o == msio_ctl_pkg::DAC_MODE_PRESET2);
   assign dac_preset_value_o =
      (dac_update_mode_o == msio_ctl_pkg::DAC_MODE_PRESET2) ?
      r_q.pre2 : r_q.pre1;

   // ****************************************************************
   // Assertions.
   // ****************************************************************
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);

   logic ctl_wr; // Helper: a word is written to the control register.
   assign ctl_wr = is_write && !acc_start_i &&
                   (r_q.addr == msio_ctl_pkg::DEVICE_CONTROL_OFS);

   sequence soft_reset_write;
      ctl_wr && acc_wdata_i[msio_ctl_pkg::SOFT_RESET_BIT];
   endsequence

   sequence reset_then_defaults;
      device_reset_o && ports_hiz_o ##1
      (r_q.ctl == 16'h0000 && gpo_level_o == 20'h00000);
   endsequence

   a_overtemp_trip: assert property (
      overtemp && !device_reset_o |=>
      device_reset_o && ports_hiz_o ##1 !low_power_sel_o)
      else $error("overtemperature did not reset the device");
   a_no_trip_off: assert property (
      !r_q.ctl[msio_ctl_pkg::OVERTEMP_BIT] && !ctl_wr |=> !device_reset_o)
      else $error("device reset with shutdown disabled");
   a_monitor_map: assert property (
      ctl_wr && !acc_wdata_i[15] && !overtemp |=>
      temp_monitor_enables_o == $past(acc_wdata_i[10:8]))
      else $error("monitor enables do not follow the write");
   a_conv_time: assert property (
      ctl_wr && !acc_wdata_i[15] && !overtemp |=>
      temp_conv_time_sel_o == $past(acc_wdata_i[11]))
      else $error("conversion time select wrong");
   a_low_power_hiz: assert property (
      low_power_sel_o |-> ports_hiz_o && gpo_oe_o == 20'h00000)
      else $error("ports driven in low power");
   a_lp_exit_seq: assert property (
      ctl_wr && low_power_sel_o && !acc_wdata_i[13] && !acc_wdata_i[15]
      |=> power_on_seq_o ##1 !power_on_seq_o)
      else $error("no power-on sequence after low power");
   a_plain_step: assert property (
      acc_valid_i && !acc_start_i && !r_q.rst_req &&
      !r_q.ctl[msio_ctl_pkg::BURST_POLICY_BIT]
      |=> acc_addr_o == 7'($past(acc_addr_o) + 7'h01))
      else $error("plain burst did not add one");
   a_ctx_step: assert property (
      ctx_step && seek_found && !acc_start_i && !r_q.rst_req |=>
      ($past(acc_write_i) ? $past(port_is_dac_i[seek_next])
                          : $past(port_is_adc_i[seek_next])))
      else $error("contextual step hit an unconfigured port");
   a_dac_read_plain: assert property (
      is_read && in_dac && !acc_start_i && !r_q.rst_req
      |=> acc_addr_o == 7'($past(acc_addr_o) + 7'h01))
      else $error("DAC read stepped contextually");
   a_soft_reset: assert property (
      soft_reset_write |=> reset_then_defaults)
      else $error("soft reset did not restore defaults");
   a_reset_bit_zero: assert property (
      acc_rvalid_o && $past(r_q.addr) == msio_ctl_pkg::DEVICE_CONTROL_OFS
      |-> !acc_rdata_o[15])
      else $error("soft reset bit read back as one");
   a_gpo_drive: assert property (
      (r_q.gpo[0] && port_is_gpo_i[0]) == gpo_level_o[0])
      else $error("GPO port 0 level wrong");
   a_preset_pick: assert property (
      dac_update_mode_o == msio_ctl_pkg::DAC_MODE_PRESET1 |->
      dac_preset_active_o && dac_preset_value_o == r_q.pre1)
      else $error("preset one not selected");
   a_input_high_zero: assert property (
      is_read && !acc_start_i && !r_q.rst_req &&
      r_q.addr == msio_ctl_pkg::INPUT_LEVEL_HIGH_OFS
      |=> acc_rdata_o[15:4] == 12'h000)
      else $error("unused input bits not zero");

endmodule : msio_ctl_regs

// file: logic/msio_ctl_pkg.sv
// Constants for the mixed-signal control register bank.
// Assumes one 20 MHz system clock and a word-wide register access port.
// Behaviour
// - Enabled hot internal monitor above 145C resets device.
// - Shutdown bit clear means no overtemperature reset.
// - Three bits enable internal and two external monitors.
// - One bit selects default or extended conversion time.
// - Low power holds all analog ports high impedance.
// - Leaving low power starts the power-on sequence.
// - Plain burst steps the address by one.
// - Contextual burst skips to next ADC or DAC port.
// - Contextual stepping only for ADC reads, DAC writes.
// - Soft reset bit acts as power-on reset.
// - Input registers report levels on GPI ports.
// - Output registers drive levels on GPO ports.
// - Two 12-bit presets feed DAC-configured ports.
// - Preset writes leave per-port DAC data untouched.
// - Mode 10 picks preset one, 11 preset two.
package msio_ctl_pkg;

   // ****************************************************************
   // Register offsets on the access port.
   // ****************************************************************
   localparam logic [6:0] DEVICE_CONTROL_OFS    = 7'h10; // Control word.
   localparam logic [6:0] INPUT_LEVEL_LOW_OFS   = 7'h0b; // Ports 0..15 in.
   localparam logic [6:0] INPUT_LEVEL_HIGH_OFS  = 7'h0c; // Ports 16..19 in.
   localparam logic [6:0] OUTPUT_LEVEL_LOW_OFS  = 7'h0d; // Ports 0..15 out.
   localparam logic [6:0] OUTPUT_LEVEL_HIGH_OFS = 7'h0e; // Ports 16..19 out.
   localparam logic [6:0] SHARED_DAC_ONE_OFS    = 7'h16; // First preset.
   localparam logic [6:0] SHARED_DAC_TWO_OFS    = 7'h17; // Second preset.
   localparam logic [6:0] ADC_DATA_BASE_OFS     = 7'h40; // ADC data, port 0.
   localparam logic [6:0] DAC_DATA_BASE_OFS     = 7'h60; // DAC data, port 0.

   // ****************************************************************
   // Device control field positions.
   // ****************************************************************
   localparam int DAC_MODE_LSB      = 2;  // Two-bit DAC update mode.
   localparam int DAC_REF_BIT       = 6;  // DAC reference selection.
   localparam int OVERTEMP_BIT      = 7;  // Overtemperature self reset.
   localparam int TEMP_MON_LSB      = 8;  // Three monitor enables.
   localparam int TEMP_CONV_BIT     = 11; // Conversion time selection.
   localparam int SERIES_COMP_BIT   = 12; // Series resistance cancel.
   localparam int LOW_POWER_BIT     = 13; // Low power selection.
   localparam int BURST_POLICY_BIT  = 14; // Burst addressing policy.
   localparam int SOFT_RESET_BIT    = 15; // Self-clearing soft reset.

   // ****************************************************************
   // Reset values, sizes and encodings.
   // ****************************************************************
   localparam logic [15:0] DEVICE_CONTROL_RST = 16'h0000; // After reset.
   localparam logic [19:0] OUTPUT_LEVEL_RST   = 20'h00000; // Outputs low.
   localparam logic [11:0] SHARED_DAC_RST     = 12'h000;   // Presets zero.
   localparam int          NUM_PORTS          = 20;        // Port count.
   localparam logic [1:0]  DAC_MODE_PRESET1   = 2'h2;      // Use preset one.
   localparam logic [1:0]  DAC_MODE_PRESET2   = 2'h3;      // Use preset two.

   // ****************************************************************
   // Thermal trip point, 0.125 degree steps in two's complement.
   // ****************************************************************
   localparam int          TRIP_TEMP_C     = 145; // Trip in degrees C.
   localparam int          TEMP_STEPS_PER_C = 8;  // Codes per degree.
   localparam logic [11:0] TRIP_TEMP_CODE  =
      12'(TRIP_TEMP_C * TEMP_STEPS_PER_C);

endpackage : msio_ctl_pkg

// file: logic/msio_level_sync.sv
// Two-stage synchroniser for the general-purpose input pins.
// Assumes the pins are asynchronous to clk_sys_i.
`timescale 1ns/1ps
module msio_level_sync (
   // Clock and reset.
   input  wire logic        clk_sys_i,
   input  wire logic        resetn_i,
   // Pin levels in and synchronised levels out.
   input  wire logic [19:0] pin_i,
   output logic      [19:0] level_o
);

   // ****************************************************************
   // State: first and second stage.
   // ****************************************************************
   typedef struct packed {
      logic [19:0] meta; // First stage, read only by the second.
      logic [19:0] safe; // Second stage, safe for logic.
   } sync_t;

   sync_t s_q; // Registered state.
   sync_t s_d; // Next state.

   // The next state simply shifts the pins through both stages.
   always_comb begin
      s_d      = s_q;
      s_d.meta = pin_i;
      s_d.safe = s_q.meta;
   end

   // Both stages clear under the synchronous reset.
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign level_o = s_q.safe;

endmodule : msio_level_sync

// file: logic/msio_port_seek.sv
// Finds the next port above a given one whose mask bit is set.
// Assumes a 20-port mask; the search wraps round past port 19.
`timescale 1ns/1ps
module msio_port_seek (
   // Search start and port mask.
   input  wire logic [4:0]  cur_idx_i,
   input  wire logic [19:0] mask_i,
   // Result.
   output logic      [4:0]  next_idx_o,
   output logic             found_o
);

   // Walks forward from the current port and keeps the first hit.
   always_comb begin
      int idx;
      idx        = 0;
      next_idx_o = cur_idx_i;
      found_o    = 1'b0;
      for (int k = 1; k <= msio_ctl_pkg::NUM_PORTS; k++) begin
         idx = (int'(cur_idx_i) + k) % msio_ctl_pkg::NUM_PORTS;
         if (!found_o && mask_i[idx]) begin
            next_idx_o = 5'(idx);
            found_o    = 1'b1;
         end
      end
   end

endmodule : msio_port_seek

// file: dv/msio_host_model.sv
// Host model issuing word bursts to the control register block.
// Assumes every call starts at a falling edge of clk_sys_i.
`timescale 1ns/1ps
module msio_host_model (
   // Clock and read answer.
   input  wire logic        clk_sys_i,
   input  wire logic        rvalid_i,
   input  wire logic [15:0] rdata_i,
   // Requests.
   output logic             start_o,
   output logic      [6:0]  addr_o,
   output logic             write_o,
   output logic             valid_o,
   output logic      [15:0] wdata_o
);
   initial {start_o, valid_o, write_o, addr_o, wdata_o} = '0;
   // Opens a burst at address a.
   task automatic open_burst(input logic [6:0] a);
      start_o = 1'b1;
      addr_o  = a;
      @(negedge clk_sys_i);
   endtask : open_burst
   // One word; a read answer is taken one cycle after the request.
   task automatic word(input logic w, input logic [15:0] d,
                       output logic [15:0] q, output logic rv);
      start_o = 1'b0;
      valid_o = 1'b1;
      write_o = w;
      wdata_o = d;
      @(negedge clk_sys_i);
      q  = rdata_i;
      rv = rvalid_i;
   endtask : word
   // Ends a burst; idle lines change so stale data is never seen.
   task automatic idle();
      valid_o = 1'b0;
      wdata_o = ~wdata_o;
      addr_o  = ~addr_o;
      @(negedge clk_sys_i);
   endtask : idle
endmodule : msio_host_model

// file: dv/mixed_signal_control_registers_tb.sv
// Self-checking bench: host model plus an integer reference model.
// Assumes the design package and register block are compiled first.
`timescale 1ns/1ps
module mixed_signal_control_registers_tb;
   logic        clk_sys_i, resetn_i, start, write, valid, rvalid, rv;
   logic        dev_rst, pwr_seq, lp, hiz, conv, pact, temp_v, dref, rsc;
   logic [6:0]  addr, cur_addr;
   logic [15:0] wdata, rdata, q;
   logic [19:0] adc_m, dac_m, gpi_m, gpo_m, pins, gpo_lvl, gpo_oe;
   logic [11:0] temp, pval;
   logic [2:0]  tme;
   logic [1:0]  mode, pl;
   int          ctl, gpo, p1, p2, n, error_cnt, comparisons;
   int ot[4][3] = '{'{'h180, 1160, 0}, '{'h180, 1161, 1},
                    '{'h100, 1500, 0}, '{'h080, 1500, 0}};
   msio_host_model h (.clk_sys_i, .rvalid_i(rvalid), .rdata_i(rdata),
      .start_o(start), .addr_o(addr), .write_o(write), .valid_o(valid),
      .wdata_o(wdata));
   msio_ctl_regs dut_u (.clk_sys_i, .resetn_i, .acc_start_i(start),
      .acc_addr_i(addr), .acc_write_i(write), .acc_valid_i(valid),
      .acc_wdata_i(wdata), .acc_rdata_o(rdata), .acc_rvalid_o(rvalid),
      .acc_addr_o(cur_addr), .port_is_adc_i(adc_m), .port_is_dac_i(dac_m),
      .port_is_gpi_i(gpi_m), .port_is_gpo_i(gpo_m), .gpi_pin_i(pins),
      .gpo_level_o(gpo_lvl), .gpo_oe_o(gpo_oe), .int_temp_i(temp),
      .int_temp_valid_i(temp_v), .temp_monitor_enables_o(tme),
      .temp_conv_time_sel_o(conv), .dac_reference_sel_o(dref),
      .series_resistance_comp_o(rsc), .dac_update_mode_o(mode),
      .low_power_sel_o(lp), .ports_hiz_o(hiz), .device_reset_o(dev_rst),
      .power_on_seq_o(pwr_seq), .dac_preset_active_o(pact),
      .dac_preset_value_o(pval));
   initial begin
      clk_sys_i = 1'b0;
      forever #25 clk_sys_i = ~clk_sys_i;
   end
   task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // Reference read value of each address.
   function automatic int exp_rd(int a);
      case (a)
         'h10: return ctl;
         'h0b: return pins & gpi_m & 'hffff;
         'h0c: return (pins & gpi_m) >> 16;
         'h0d: return gpo & 'hffff;
         'h0e: return gpo >> 16;
         'h16: return p1;
         'h17: return p2;
         default: return 0;
      endcase
   endfunction : exp_rd
   // Reference address step after one word.
   function automatic int next_addr(int a, bit w);
      int b = w ? 'h60 : 'h40;
      logic [19:0] m = w ? dac_m : adc_m;
      if (ctl[14] && a >= b && a < b + 20)
         for (int k = 1; k <= 20; k++)
            if (m[(a - b + k) % 20]) return b + (a - b + k) % 20;
      return a + 1;
   endfunction : next_addr
   // Single-word write; also updates the reference model.
   task automatic wr(input int a, input int d);
      h.open_burst(7'(a));
      h.word(1'b1, 16'(d), q, rv);
      pl = {dev_rst, pwr_seq};
      h.idle();
      if (a == 'h10)
         chk(20'(pl), {d[15], !d[15] && ctl[13] && !d[13]});
      case (a)
         'h10: ctl = d & 'h7fff;
         'h0d: gpo = (gpo & 'hf0000) | (d & 'hffff);
         'h0e: gpo = (gpo & 'hffff) | ((d & 'hf) << 16);
         'h16: p1 = d & 'hfff;
         'h17: p2 = d & 'hfff;
         default: ;
      endcase
      if (a == 'h10 && d[15]) {ctl, gpo, p1, p2} = '0;
   endtask : wr
   task automatic sweep();
      int al[9] = '{'h10, 'h0b, 'h0c, 'h0d, 'h0e, 'h16, 'h17, 'h15, 'h45};
      foreach (al[i]) begin
         h.open_burst(7'(al[i]));
         h.word(1'b0, 16'h0, q, rv);
         h.idle();
         chk({3'h0, rv, q}, 20'h10000 | 20'(exp_rd(al[i])));
      end
   endtask : sweep
   task automatic outs();
      chk(gpo_lvl, 20'(gpo) & gpo_m);
      chk(gpo_oe, ctl[13] ? 20'h0 : gpo_m);
      chk(20'({tme, conv, lp, hiz, dref, rsc}),
          20'({ctl[10:8], ctl[11], ctl[13], ctl[13], ctl[6], ctl[12]}));
      chk({mode, pact, 5'h0, pval}, {ctl[3:2], ctl[3], 5'h0,
          ctl[3:2] == 3 ? p2[11:0] : p1[11:0]});
   endtask : outs
   task automatic burst(input int a, input bit w);
      int c = a;
      h.open_burst(7'(a));
      repeat (5) begin
         h.word(w, 16'($urandom), q, rv);
         c = next_addr(c, w);
         chk(20'(cur_addr), 20'(c));
      end
      h.idle();
   endtask : burst
   task automatic final_report();
      $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : final_report
   initial begin
      void'($urandom(35));
      {resetn_i, temp, temp_v, adc_m, dac_m, gpi_m, gpo_m, pins} = '0;
      {ctl, gpo, p1, p2, error_cnt, comparisons} = '0;
      repeat (8) @(negedge clk_sys_i);
      resetn_i = 1'b1;
      sweep();
      outs();
      repeat (6) begin
         {adc_m, dac_m, gpi_m, gpo_m, pins} =
            100'({$urandom, $urandom, $urandom, $urandom});
         foreach (ot[i]) wr('h0d + i + (i > 1) * 7, $urandom);
         wr('h0b, $urandom);
         wr('h10, $urandom & 'h7fff);
         sweep();
         outs();
         for (int k = 0; k < 6; k++) begin
            wr('h10, (ctl & 'h3fff) | (k % 2) << 14);
            burst((k < 2 ? 'h40 : 'h60) + $urandom % 20, k / 2 == 1);
         end
      end
      wr('h10, 'ha000 | ($urandom & 'h1fff));
      sweep();
      foreach (ot[i]) begin
         wr('h10, ot[i][0]);
         {temp, temp_v} = {12'(ot[i][1]), 1'b1};
         n = 0;
         repeat (4) begin
            @(negedge clk_sys_i);
            n += dev_rst;
         end
         temp_v = 1'b0;
         chk(20'(n), 20'(ot[i][2]));
         if (ot[i][2] == 1) {ctl, gpo, p1, p2} = '0;
      end
      sweep();
      outs();
      final_report();
   end
endmodule : mixed_signal_control_registers_tb
